// ===== core/phase_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// wakeup timer: counts one phase, done pulses on its last cycle
module phase_timer (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    phase_timer_if.timer tmr
);
    typedef struct packed {
        logic [sleep_cfg_pkg::cnt_w-1:0] count;
        logic busy;
    } tmr_state_t;
    tmr_state_t state_ff;
    tmr_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (tmr.load) begin
            nxt_state.count = tmr.length;
            nxt_state.busy = 1'b1;
        end else if (state_ff.busy) begin
            nxt_state.count = state_ff.count - 1'b1;
            if (state_ff.count == sleep_cfg_pkg::cnt_w'(1)) begin
                nxt_state.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= '0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // done never looks at load: the controller raises load from done
    assign tmr.done = clk_en && state_ff.busy
        && (state_ff.count == sleep_cfg_pkg::cnt_w'(1));
endmodule // phase_timer
`default_nettype wire

// ===== core/phase_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface phase_timer_if;
    logic load;
    logic [sleep_cfg_pkg::cnt_w-1:0] length;
    logic done;
    modport ctrl (output load, output length, input done);
    modport timer (input load, input length, output done);
endinterface
`default_nettype wire

// ===== core/sleep_cfg_pkg.sv
package sleep_cfg_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] power_cfg_addr = 8'hEC;
    localparam logic [7:0] tap_cfg_addr = 8'hED;
    localparam logic [7:0] power_cfg_reset = 8'h00;
    localparam logic [7:0] tap_cfg_reset = 8'h7F;
    // ==========================================================
    // field positions
    localparam int osc_off_bit = 0;
    localparam int bus_keep_bit = 1;
    localparam int alt_rate_lsb = 2;
    localparam int phase1_lsb = 0;
    localparam int phase2_lsb = 2;
    localparam int phase3_lsb = 4;
    localparam int double_bit = 6;
    // ==========================================================
    // pulse rate codes
    localparam logic [1:0] rate_legacy = 2'h0;
    localparam logic [1:0] rate_32k = 2'h1;
    localparam logic [1:0] rate_8k = 2'h2;
    localparam logic [1:0] rate_reserved = 2'h3;
    // ==========================================================
    // phase times in nanoseconds, cycles derived from the clock period
    localparam int clk_period_ns = 50;
    localparam int p1_ns_0 = 10000;
    localparam int p1_ns_1 = 14000;
    localparam int p1_ns_2 = 20000;
    localparam int p1_ns_3 = 30000;
    localparam int p2_ns_0 = 3000;
    localparam int p2_ns_1 = 4000;
    localparam int p2_ns_2 = 5000;
    localparam int p2_ns_3 = 10000;
    localparam int p3_ns_0 = 1000;
    localparam int p3_ns_1 = 2000;
    localparam int p3_ns_2 = 5000;
    localparam int p3_ns_3 = 10000;
    localparam int cnt_w = 12;
    localparam logic [cnt_w-1:0] p1_cyc_0 = cnt_w'((p1_ns_0 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p1_cyc_1 = cnt_w'((p1_ns_1 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p1_cyc_2 = cnt_w'((p1_ns_2 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p1_cyc_3 = cnt_w'((p1_ns_3 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p2_cyc_0 = cnt_w'((p2_ns_0 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p2_cyc_1 = cnt_w'((p2_ns_1 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p2_cyc_2 = cnt_w'((p2_ns_2 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p2_cyc_3 = cnt_w'((p2_ns_3 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p3_cyc_0 = cnt_w'((p3_ns_0 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p3_cyc_1 = cnt_w'((p3_ns_1 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p3_cyc_2 = cnt_w'((p3_ns_2 + clk_period_ns - 1) / clk_period_ns);
    localparam logic [cnt_w-1:0] p3_cyc_3 = cnt_w'((p3_ns_3 + clk_period_ns - 1) / clk_period_ns);
    // ==========================================================
    // wakeup sequencer states
    typedef enum logic [4:0] {
        st_run = 5'h01,
        st_sleep = 5'h02,
        st_phase1 = 5'h04,
        st_phase2 = 5'h08,
        st_phase3 = 5'h10
    } seq_state_t;
endpackage

// ===== core/sleep_wakeup_config.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_config (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sleep_req,
    input wire logic pin_wake,
    input wire logic timer_wake,
    input wire logic [1:0] legacy_pulse_rate_sel,
    output logic [1:0] pulse_rate_mode,
    output logic [1:0] legacy_rate_out,
    output logic slow_osc_en,
    output logic standby_reg_on,
    output logic bus_supply_on,
    output logic sleep_timer_run,
    output logic watchdog_run,
    output logic pulse_run,
    output logic deep_sleep,
    output logic asleep,
    output logic waking,
    output logic [1:0] wake_phase,
    output logic core_run
);
    typedef struct packed {
        logic [7:0] power_cfg;
        logic [7:0] tap_cfg;
        logic [7:0] rdata;
        logic deep;
        sleep_cfg_pkg::seq_state_t seq;
        logic [7:0] chk_tap;
        logic [sleep_cfg_pkg::cnt_w-1:0] phase_cyc;
    } top_state_t;
    top_state_t state_ff;
    top_state_t nxt_state;

    phase_timer_if tmr_bus ();

    phase_timer u_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tmr(tmr_bus.timer)
    );

    logic osc_off;
    logic bus_keep;
    logic dbl;
    logic [1:0] p1_sel;
    logic [1:0] p2_sel;
    logic [1:0] p3_sel;
    logic [sleep_cfg_pkg::cnt_w-1:0] p1_len;
    logic [sleep_cfg_pkg::cnt_w-1:0] p2_len;
    logic [sleep_cfg_pkg::cnt_w-1:0] p3_len;
    logic wake_evt;
    logic in_sleep;

    assign osc_off = state_ff.power_cfg[sleep_cfg_pkg::osc_off_bit];
    assign bus_keep = state_ff.power_cfg[sleep_cfg_pkg::bus_keep_bit];
    assign dbl = state_ff.tap_cfg[sleep_cfg_pkg::double_bit];
    assign p1_sel = state_ff.tap_cfg[sleep_cfg_pkg::phase1_lsb +: 2];
    assign p2_sel = state_ff.tap_cfg[sleep_cfg_pkg::phase2_lsb +: 2];
    assign p3_sel = state_ff.tap_cfg[sleep_cfg_pkg::phase3_lsb +: 2];

    // ==========================================================
    // phase lengths
    always_comb begin
        case (p1_sel)
            2'h0: p1_len = sleep_cfg_pkg::p1_cyc_0;
            2'h1: p1_len = sleep_cfg_pkg::p1_cyc_1;
            2'h2: p1_len = sleep_cfg_pkg::p1_cyc_2;
            default: p1_len = sleep_cfg_pkg::p1_cyc_3;
        endcase
        case (p2_sel)
            2'h0: p2_len = sleep_cfg_pkg::p2_cyc_0;
            2'h1: p2_len = sleep_cfg_pkg::p2_cyc_1;
            2'h2: p2_len = sleep_cfg_pkg::p2_cyc_2;
            default: p2_len = sleep_cfg_pkg::p2_cyc_3;
        endcase
        case (p3_sel)
            2'h0: p3_len = sleep_cfg_pkg::p3_cyc_0;
            2'h1: p3_len = sleep_cfg_pkg::p3_cyc_1;
            2'h2: p3_len = sleep_cfg_pkg::p3_cyc_2;
            default: p3_len = sleep_cfg_pkg::p3_cyc_3;
        endcase
        if (dbl) begin
            p1_len = {p1_len[sleep_cfg_pkg::cnt_w-2:0], 1'b0};
            p2_len = {p2_len[sleep_cfg_pkg::cnt_w-2:0], 1'b0};
            p3_len = {p3_len[sleep_cfg_pkg::cnt_w-2:0], 1'b0};
        end
    end

    // ==========================================================
    // sequencer and registers
    assign in_sleep = (state_ff.seq == sleep_cfg_pkg::st_sleep);
    // deep sleep ignores the timer source
    assign wake_evt = pin_wake || (!state_ff.deep && timer_wake);

    always_comb begin
        nxt_state = state_ff;
        tmr_bus.load = 1'b0;
        tmr_bus.length = p1_len;
        nxt_state.rdata = 8'h00;
        if (reg_wr && reg_addr == sleep_cfg_pkg::power_cfg_addr) begin
            nxt_state.power_cfg = {4'h0, reg_wdata[3:0]};
        end
        if (reg_wr && reg_addr == sleep_cfg_pkg::tap_cfg_addr) begin
            nxt_state.tap_cfg = {1'b0, reg_wdata[6:0]};
        end
        if (reg_rd) begin
            case (reg_addr)
                sleep_cfg_pkg::power_cfg_addr: nxt_state.rdata = state_ff.power_cfg;
                sleep_cfg_pkg::tap_cfg_addr: nxt_state.rdata = state_ff.tap_cfg;
                default: nxt_state.rdata = 8'h00;
            endcase
        end
        case (state_ff.seq)
            sleep_cfg_pkg::st_run: begin
                if (sleep_req) begin
                    nxt_state.seq = sleep_cfg_pkg::st_sleep;
                    nxt_state.deep = osc_off && !bus_keep;
                end
            end
            sleep_cfg_pkg::st_sleep: begin
                if (wake_evt) begin
                    nxt_state.seq = sleep_cfg_pkg::st_phase1;
                    nxt_state.deep = 1'b0;
                    tmr_bus.load = 1'b1;
                    tmr_bus.length = p1_len;
                end
            end
            sleep_cfg_pkg::st_phase1: begin
                if (tmr_bus.done) begin
                    nxt_state.seq = sleep_cfg_pkg::st_phase2;
                    tmr_bus.load = 1'b1;
                    tmr_bus.length = p2_len;
                end
            end
            sleep_cfg_pkg::st_phase2: begin
                if (tmr_bus.done) begin
                    nxt_state.seq = sleep_cfg_pkg::st_phase3;
                    tmr_bus.load = 1'b1;
                    tmr_bus.length = p3_len;
                end
            end
            sleep_cfg_pkg::st_phase3: begin
                if (tmr_bus.done) begin
                    nxt_state.seq = sleep_cfg_pkg::st_run;
                end
            end
            default: nxt_state.seq = sleep_cfg_pkg::st_run;
        endcase
        if (!clk_en) begin
            tmr_bus.load = 1'b0;
        end
        // taps seen at each phase load and cycles spent so far in the phase
        if (tmr_bus.load) begin
            nxt_state.chk_tap = state_ff.tap_cfg;
        end
        if (!waking || tmr_bus.done) begin
            nxt_state.phase_cyc = '0;
        end else begin
            nxt_state.phase_cyc = state_ff.phase_cyc + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff.power_cfg <= sleep_cfg_pkg::power_cfg_reset;
            state_ff.tap_cfg <= sleep_cfg_pkg::tap_cfg_reset;
            state_ff.rdata <= 8'h00;
            state_ff.deep <= 1'b0;
            state_ff.seq <= sleep_cfg_pkg::st_run;
            state_ff.chk_tap <= sleep_cfg_pkg::tap_cfg_reset;
            state_ff.phase_cyc <= '0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata = state_ff.rdata;
    assign pulse_rate_mode = state_ff.power_cfg[sleep_cfg_pkg::alt_rate_lsb +: 2];
    assign legacy_rate_out = (pulse_rate_mode == sleep_cfg_pkg::rate_legacy)
        ? legacy_pulse_rate_sel : 2'h0;
    assign slow_osc_en = !(in_sleep && osc_off);
    assign sleep_timer_run = slow_osc_en;
    assign watchdog_run = slow_osc_en;
    assign pulse_run = slow_osc_en;
    assign standby_reg_on = !in_sleep || !osc_off || bus_keep;
    assign bus_supply_on = !in_sleep || bus_keep;
    assign deep_sleep = in_sleep && state_ff.deep;
    assign asleep = in_sleep;
    assign waking = (state_ff.seq == sleep_cfg_pkg::st_phase1)
        || (state_ff.seq == sleep_cfg_pkg::st_phase2)
        || (state_ff.seq == sleep_cfg_pkg::st_phase3);
    assign wake_phase = (state_ff.seq == sleep_cfg_pkg::st_phase2) ? 2'h2
        : (state_ff.seq == sleep_cfg_pkg::st_phase3) ? 2'h3
        : (state_ff.seq == sleep_cfg_pkg::st_phase1) ? 2'h1 : 2'h0;
    assign core_run = (state_ff.seq == sleep_cfg_pkg::st_run);

    // ==========================================================
    // checks
    sequence wake_start_s;
        in_sleep && wake_evt && clk_en;
    endsequence

    reg_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_rd && clk_en && reg_addr == sleep_cfg_pkg::tap_cfg_addr
        |=> reg_rdata == $past(state_ff.tap_cfg)) else $error("tap read wrong");
    legacy_rate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        pulse_rate_mode == 2'h0 |-> legacy_rate_out == legacy_pulse_rate_sel)
        else $error("legacy rate not passed");
    bus_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        in_sleep && bus_keep |-> bus_supply_on && standby_reg_on)
        else $error("bus supply dropped");
    osc_sleep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        in_sleep && !osc_off |-> slow_osc_en && sleep_timer_run && standby_reg_on)
        else $error("oscillator stopped");
    osc_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        in_sleep && osc_off |-> !sleep_timer_run && !watchdog_run && !pulse_run)
        else $error("timers run in sleep");
    deep_entry_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        core_run && sleep_req && clk_en && osc_off && !bus_keep |=> deep_sleep)
        else $error("deep sleep not entered");
    deep_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        deep_sleep && !pin_wake |=> deep_sleep)
        else $error("deep sleep left without pin");
    phase_order_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wake_start_s |=> wake_phase == 2'h1) else $error("phase one missing");
    phase1_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wake_start_s ##1 (clk_en && p1_sel == 2'h0 && !dbl)[*8]
        |-> wake_phase == 2'h1) else $error("phase one short");

    // ==========================================================
    // expected length of the running phase, from the taps latched at its load
    logic [1:0] exp_sel;
    logic [sleep_cfg_pkg::cnt_w-1:0] exp_len;

    always_comb begin
        case (wake_phase)
            2'h1: exp_sel = state_ff.chk_tap[sleep_cfg_pkg::phase1_lsb +: 2];
            2'h2: exp_sel = state_ff.chk_tap[sleep_cfg_pkg::phase2_lsb +: 2];
            default: exp_sel = state_ff.chk_tap[sleep_cfg_pkg::phase3_lsb +: 2];
        endcase
        case ({wake_phase, exp_sel})
            4'h4: exp_len = sleep_cfg_pkg::p1_cyc_0;
            4'h5: exp_len = sleep_cfg_pkg::p1_cyc_1;
            4'h6: exp_len = sleep_cfg_pkg::p1_cyc_2;
            4'h7: exp_len = sleep_cfg_pkg::p1_cyc_3;
            4'h8: exp_len = sleep_cfg_pkg::p2_cyc_0;
            4'h9: exp_len = sleep_cfg_pkg::p2_cyc_1;
            4'hA: exp_len = sleep_cfg_pkg::p2_cyc_2;
            4'hB: exp_len = sleep_cfg_pkg::p2_cyc_3;
            4'hC: exp_len = sleep_cfg_pkg::p3_cyc_0;
            4'hD: exp_len = sleep_cfg_pkg::p3_cyc_1;
            4'hE: exp_len = sleep_cfg_pkg::p3_cyc_2;
            4'hF: exp_len = sleep_cfg_pkg::p3_cyc_3;
            default: exp_len = '0;
        endcase
        if (state_ff.chk_tap[sleep_cfg_pkg::double_bit]) begin
            exp_len = exp_len + exp_len;
        end
    end

    sequence phase_end_s(logic [1:0] p);
        wake_phase == p && tmr_bus.done;
    endsequence

    phase1_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        phase_end_s(2'h1) |-> state_ff.phase_cyc == exp_len - 1'b1)
        else $error("phase one length wrong");
    phase2_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        phase_end_s(2'h2) |-> state_ff.phase_cyc == exp_len - 1'b1)
        else $error("phase two length wrong");
    phase3_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        phase_end_s(2'h3) |-> state_ff.phase_cyc == exp_len - 1'b1)
        else $error("phase three length wrong");
    phase_early_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        waking && state_ff.phase_cyc + 1'b1 < exp_len |-> !tmr_bus.done)
        else $error("phase ended early");
    step_two_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        phase_end_s(2'h1) |=> wake_phase == 2'h2)
        else $error("phase two skipped");
    step_three_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        phase_end_s(2'h2) |=> wake_phase == 2'h3)
        else $error("phase three skipped");
    wake_done_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        phase_end_s(2'h3) |=> core_run)
        else $error("run not resumed");
    osc_run_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !in_sleep |-> slow_osc_en && watchdog_run && pulse_run)
        else $error("oscillator stopped while awake");
    deep_power_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        deep_sleep |-> !standby_reg_on && !bus_supply_on && !slow_osc_en)
        else $error("deep sleep still powered");
endmodule // sleep_wakeup_config
`default_nettype wire

// ===== sim/sleep_wakeup_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_config_tb;
    // ==========================================================
    // stimulus and observed signals
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep_req = 1'b0;
    logic pin_wake = 1'b0;
    logic timer_wake = 1'b0;
    logic [1:0] legacy_pulse_rate_sel = 2'h0;
    logic [7:0] reg_rdata;
    logic [1:0] pulse_rate_mode, legacy_rate_out, wake_phase;
    logic slow_osc_en, standby_reg_on, bus_supply_on, sleep_timer_run, watchdog_run;
    logic pulse_run, deep_sleep, asleep, waking, core_run;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    integer seed = 32'hAB83;

    sleep_wakeup_config u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_req(sleep_req), .pin_wake(pin_wake),
        .timer_wake(timer_wake), .legacy_pulse_rate_sel(legacy_pulse_rate_sel),
        .pulse_rate_mode(pulse_rate_mode), .legacy_rate_out(legacy_rate_out),
        .slow_osc_en(slow_osc_en), .standby_reg_on(standby_reg_on),
        .bus_supply_on(bus_supply_on), .sleep_timer_run(sleep_timer_run),
        .watchdog_run(watchdog_run), .pulse_run(pulse_run), .deep_sleep(deep_sleep),
        .asleep(asleep), .waking(waking), .wake_phase(wake_phase), .core_run(core_run)
    );

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // ==========================================================
    // reporting
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // hang guard: the whole run needs well under this many cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // ==========================================================
    // register bus and event drivers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check("reg_rdata", exp, reg_rdata);
        @(negedge core_clk);
        check("reg_rdata idle", 8'h00, reg_rdata);
    endtask

    // one-cycle pulse on {sleep_req, pin_wake, timer_wake}, ends where it was taken
    task automatic evt(input logic [2:0] m);
        @(posedge core_clk);
        {sleep_req, pin_wake, timer_wake} <= m;
        @(posedge core_clk);
        {sleep_req, pin_wake, timer_wake} <= 3'h0;
        @(negedge core_clk);
    endtask

    // phase length in cycles, 20 cycles per microsecond
    function automatic int plen(input int p, input logic [7:0] tap);
        int t1 [4] = '{200, 280, 400, 600};
        int t2 [4] = '{60, 80, 100, 200};
        int t3 [4] = '{20, 40, 100, 200};
        int n;
        n = (p == 1) ? t1[tap[1:0]] : (p == 2) ? t2[tap[3:2]] : t3[tap[5:4]];
        return tap[6] ? 2 * n : n;
    endfunction

    task automatic run_wake(input logic [7:0] tap);
        int n;
        check("waking", 1'b1, waking);
        for (int p = 1; p <= 3; p++) begin
            n = 0;
            while (wake_phase === 2'(p) && n < 3000) begin
                n++;
                @(negedge core_clk);
            end
            check("phase length", 16'(plen(p, tap)), 16'(n));
        end
        check("core_run", 1'b1, core_run);
        check("slow_osc_en run", 1'b1, slow_osc_en);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] v;
        logic [1:0] c;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        check("core_run reset", 1'b1, core_run);
        rd_chk(sleep_cfg_pkg::power_cfg_addr, 8'h00);
        rd_chk(sleep_cfg_pkg::tap_cfg_addr, 8'h7F);
        wr(8'hEE, 8'hFF);
        rd_chk(8'hEE, 8'h00);
        rd_chk(sleep_cfg_pkg::power_cfg_addr, 8'h00);
        // random read-back; reserved rate code kept out, unused bits read zero
        repeat (6) begin
            v = 8'($random(seed));
            v[3] = v[3] & ~v[2];
            wr(sleep_cfg_pkg::power_cfg_addr, v);
            rd_chk(sleep_cfg_pkg::power_cfg_addr, v & 8'h0F);
            v = 8'($random(seed));
            wr(sleep_cfg_pkg::tap_cfg_addr, v);
            rd_chk(sleep_cfg_pkg::tap_cfg_addr, v & 8'h7F);
        end
        for (int r = 0; r < 3; r++) begin
            c = 2'(r);
            wr(sleep_cfg_pkg::power_cfg_addr, {4'h0, c, 2'h0});
            repeat (3) begin
                @(posedge core_clk);
                legacy_pulse_rate_sel <= 2'($random(seed));
                @(negedge core_clk);
                check("pulse_rate_mode", c, pulse_rate_mode);
                check("legacy_rate_out", (c == 2'h0) ? legacy_pulse_rate_sel : 2'h0,
                      legacy_rate_out);
            end
        end
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 8'h7F : (k == 2) ? 8'h00 : 8'($random(seed)) & 8'h7F;
            wr(sleep_cfg_pkg::tap_cfg_addr, v);
            wr(sleep_cfg_pkg::power_cfg_addr, 8'(k));
            evt(3'h4);
            check("asleep", 1'b1, asleep);
            check("slow_osc_en", !k[0], slow_osc_en);
            check("timers", {3{!k[0]}}, {sleep_timer_run, watchdog_run, pulse_run});
            check("standby_reg_on", k != 1, standby_reg_on);
            check("bus_supply_on", k[1], bus_supply_on);
            check("deep_sleep", k == 1, deep_sleep);
            evt(3'h1);
            if (k == 1) begin
                check("asleep deep", 1'b1, asleep);
                // a pin wake while the clock enable is low is lost
                @(posedge core_clk);
                clk_en <= 1'b0;
                evt(3'h2);
                check("asleep frozen", 1'b1, asleep);
                check("deep_sleep frozen", 1'b1, deep_sleep);
                @(posedge core_clk);
                clk_en <= 1'b1;
                evt(3'h2);
            end
            run_wake(v);
        end
        stop_test();
    end
endmodule // sleep_wakeup_config_tb
`default_nettype wire
